//--- hdl/pwm_pkg.sv
`default_nettype none
package pwm_pkg;
  localparam int NUM_TIMERS = 3;
  // Register byte offsets
  localparam logic [7:0] OFF_CH5_CTRL = 8'h00;
  localparam logic [7:0] OFF_CH5_DCH = 8'h04;
  localparam logic [7:0] OFF_CH5_DCL = 8'h08;
  localparam logic [7:0] OFF_CH6_CTRL = 8'h0C;
  localparam logic [7:0] OFF_CH6_DCH = 8'h10;
  localparam logic [7:0] OFF_CH6_DCL = 8'h14;
  localparam logic [7:0] OFF_TSEL = 8'h18;
  localparam logic [7:0] OFF_RES = 8'h1C;
  // Field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int DCL_LSB_POS = 6;
  localparam int TSEL_CH6_POS = 2;
  localparam int TSEL_CH5_POS = 0;
  localparam int RES_CH6_POS = 8;
  // Reset values
  localparam logic [1:0] TSEL_RESET_CODE = 2'h1;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  // Timer select codes and AHB transfer types
  localparam logic [1:0] SEL_RESERVED = 2'h0;
  localparam logic [1:0] SEL_TIMER_ONE = 2'h1;
  localparam logic [1:0] SEL_TIMER_TWO = 2'h2;
  localparam logic [1:0] SEL_TIMER_THREE = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // One shared timer as seen by a channel
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic [1:0] frac;
    logic inc;
  } timer_bus_t;

  // Channel configuration from registers
  typedef struct packed {
    logic enable;
    logic polarity;
    logic [9:0] duty;
  } chan_cfg_t;

  // Resolution in bits: 2 + floor(log2(period + 1))
  function automatic logic [3:0] duty_resolution(input logic [7:0] per);
    logic [8:0] span;
    logic [3:0] res;
    span = {1'b0, per} + 9'h001;
    res = 4'h2;
    for (int i = 1; i < 9; i++) begin
      if (span[i]) begin
        res = 4'(i + 2);
      end
    end
    return res;
  endfunction : duty_resolution
endpackage : pwm_pkg
`default_nettype wire

//--- hdl/timer_mux.sv
`timescale 1ns/1ps
`default_nettype none
module timer_mux
  import pwm_pkg::*;
(
  // Timer select
  input wire logic [1:0] sel,
  // Shared timers
  input wire timer_bus_t [NUM_TIMERS-1:0] timers,
  // Selected timer
  output timer_bus_t picked,
  output logic picked_valid
);
  always_comb begin
    picked = '0;
    picked_valid = 1'b1;
    unique case (sel)
      SEL_TIMER_ONE: picked = timers[0];
      SEL_TIMER_TWO: picked = timers[1];
      SEL_TIMER_THREE: picked = timers[2];
      SEL_RESERVED: picked_valid = 1'b0;
    endcase
  end
endmodule : timer_mux
`default_nettype wire

//--- hdl/pwm_channel.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Selected timer
  input wire timer_bus_t tmr,
  input wire logic tmr_valid,
  // Configuration
  input wire chan_cfg_t cfg,
  // Outputs
  output logic pwm_out,
  output logic timer_clear,
  output logic [9:0] duty_latched
);
  logic active_reg, active_next;
  logic [9:0] duty_lat_reg, duty_lat_next;
  logic pin_reg, pin_next;
  logic wrap;
  logic [9:0] timebase;

  assign timebase = {tmr.count, tmr.frac};
  assign wrap = tmr_valid && tmr.inc && (tmr.count == tmr.period);
  assign timer_clear = wrap;
  assign pwm_out = pin_reg;
  assign duty_latched = duty_lat_reg;

  always_comb begin
    active_next = active_reg;
    duty_lat_next = duty_lat_reg;
    if (wrap) begin
      duty_lat_next = cfg.duty;
      active_next = (cfg.duty != 10'h000);
    end else if (tmr_valid && timebase >= duty_lat_reg) begin
      active_next = 1'b0;
    end
    // Disabled channel sits at its default level
    pin_next = cfg.enable ? (active_next ^ cfg.polarity)
                          : cfg.polarity;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_reg <= 1'b0;
      duty_lat_reg <= 10'h000;
      pin_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      duty_lat_reg <= duty_lat_next;
      pin_reg <= pin_next;
    end
  end

  a_disabled_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !cfg.enable |=> pwm_out == $past(cfg.polarity))
    else $error("disabled channel not at polarity level");

  a_duty_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wrap |=> duty_lat_reg == $past(cfg.duty))
    else $error("duty not latched at period match");

  a_wrap_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wrap && cfg.enable && cfg.duty != 10'h000
    |=> pwm_out == !$past(cfg.polarity))
    else $error("output not set at period start");

  a_zero_duty: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wrap && cfg.duty == 10'h000 |=> !active_reg)
    else $error("zero duty set the output");

  a_duty_ends: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tmr_valid && !wrap && {tmr.count, tmr.frac} >= duty_lat_reg
    |=> !active_reg)
    else $error("pulse not ended at duty compare");
endmodule : pwm_channel
`default_nettype wire

//--- hdl/pwm_timer_source_select.sv
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_source_select
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Shared timers
  input wire timer_bus_t [NUM_TIMERS-1:0] timers,
  output logic [NUM_TIMERS-1:0] timer_clear,
  // Channel outputs
  output logic chan_five_out,
  output logic chan_six_out
);
  // Register state
  logic ch5_en_reg, ch5_en_next;
  logic ch5_pol_reg, ch5_pol_next;
  logic [7:0] ch5_dch_reg, ch5_dch_next;
  logic [1:0] ch5_dcl_reg, ch5_dcl_next;
  logic ch6_en_reg, ch6_en_next;
  logic ch6_pol_reg, ch6_pol_next;
  logic [7:0] ch6_dch_reg, ch6_dch_next;
  logic [1:0] ch6_dcl_reg, ch6_dcl_next;
  logic [1:0] chan_six_timer_sel_reg, chan_six_timer_sel_next;
  logic [1:0] chan_five_timer_sel_reg, chan_five_timer_sel_next;

  // Bus state
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic rd_tsel_reg, rd_tsel_next;
  logic addr_phase;

  // Channel wiring
  timer_bus_t ch5_tmr, ch6_tmr;
  logic ch5_valid, ch6_valid;
  chan_cfg_t ch5_cfg, ch6_cfg;
  logic ch5_clear, ch6_clear;
  logic [3:0] ch5_res, ch6_res;

  assign addr_phase = hsel && hready &&
                      (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Register writes land in the data phase
  always_comb begin
    ch5_en_next = ch5_en_reg;
    ch5_pol_next = ch5_pol_reg;
    ch5_dch_next = ch5_dch_reg;
    ch5_dcl_next = ch5_dcl_reg;
    ch6_en_next = ch6_en_reg;
    ch6_pol_next = ch6_pol_reg;
    ch6_dch_next = ch6_dch_reg;
    ch6_dcl_next = ch6_dcl_reg;
    chan_six_timer_sel_next = chan_six_timer_sel_reg;
    chan_five_timer_sel_next = chan_five_timer_sel_reg;
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        OFF_CH5_CTRL: begin
          ch5_en_next = hwdata[CTRL_EN_BIT];
          ch5_pol_next = hwdata[CTRL_POL_BIT];
        end
        OFF_CH5_DCH: ch5_dch_next = hwdata[7:0];
        OFF_CH5_DCL: ch5_dcl_next = hwdata[DCL_LSB_POS +: 2];
        OFF_CH6_CTRL: begin
          ch6_en_next = hwdata[CTRL_EN_BIT];
          ch6_pol_next = hwdata[CTRL_POL_BIT];
        end
        OFF_CH6_DCH: ch6_dch_next = hwdata[7:0];
        OFF_CH6_DCL: ch6_dcl_next = hwdata[DCL_LSB_POS +: 2];
        OFF_TSEL: begin
          chan_six_timer_sel_next = hwdata[TSEL_CH6_POS +: 2];
          chan_five_timer_sel_next = hwdata[TSEL_CH5_POS +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ch5_en_reg <= 1'b0;
      ch5_pol_reg <= 1'b0;
      ch5_dch_reg <= DUTY_RESET;
      ch5_dcl_reg <= 2'h0;
      ch6_en_reg <= 1'b0;
      ch6_pol_reg <= 1'b0;
      ch6_dch_reg <= DUTY_RESET;
      ch6_dcl_reg <= 2'h0;
      chan_six_timer_sel_reg <= TSEL_RESET_CODE;
      chan_five_timer_sel_reg <= TSEL_RESET_CODE;
    end else begin
      ch5_en_reg <= ch5_en_next;
      ch5_pol_reg <= ch5_pol_next;
      ch5_dch_reg <= ch5_dch_next;
      ch5_dcl_reg <= ch5_dcl_next;
      ch6_en_reg <= ch6_en_next;
      ch6_pol_reg <= ch6_pol_next;
      ch6_dch_reg <= ch6_dch_next;
      ch6_dcl_reg <= ch6_dcl_next;
      chan_six_timer_sel_reg <= chan_six_timer_sel_next;
      chan_five_timer_sel_reg <= chan_five_timer_sel_next;
    end
  end

  // Address phase decode and read data, from next values so a read
  // right after a write sees the new contents
  always_comb begin
    wr_pend_next = addr_phase && hwrite
                   && haddr[31:8] == 24'h00_0000;
    wr_addr_next = addr_phase ? {haddr[7:2], 2'b00} : wr_addr_reg;
    rd_tsel_next = 1'b0;
    hrdata_next = 32'h0000_0000;
    if (addr_phase && !hwrite && haddr[31:8] == 24'h00_0000) begin
      case ({haddr[7:2], 2'b00})
        OFF_CH5_CTRL: begin
          hrdata_next[CTRL_EN_BIT] = ch5_en_next;
          hrdata_next[CTRL_OUT_BIT] = chan_five_out;
          hrdata_next[CTRL_POL_BIT] = ch5_pol_next;
        end
        OFF_CH5_DCH: hrdata_next[7:0] = ch5_dch_next;
        OFF_CH5_DCL: hrdata_next[DCL_LSB_POS +: 2] = ch5_dcl_next;
        OFF_CH6_CTRL: begin
          hrdata_next[CTRL_EN_BIT] = ch6_en_next;
          hrdata_next[CTRL_OUT_BIT] = chan_six_out;
          hrdata_next[CTRL_POL_BIT] = ch6_pol_next;
        end
        OFF_CH6_DCH: hrdata_next[7:0] = ch6_dch_next;
        OFF_CH6_DCL: hrdata_next[DCL_LSB_POS +: 2] = ch6_dcl_next;
        OFF_TSEL: begin
          rd_tsel_next = 1'b1;
          hrdata_next[TSEL_CH6_POS +: 2] = chan_six_timer_sel_next;
          hrdata_next[TSEL_CH5_POS +: 2] = chan_five_timer_sel_next;
        end
        OFF_RES: begin
          hrdata_next[3:0] = ch5_res;
          hrdata_next[RES_CH6_POS +: 4] = ch6_res;
        end
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      rd_tsel_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      rd_tsel_reg <= rd_tsel_next;
    end
  end

  // Each channel has its own selector
  timer_mux u_mux_five (
    .sel(chan_five_timer_sel_reg),
    .timers(timers),
    .picked(ch5_tmr),
    .picked_valid(ch5_valid)
  );

  timer_mux u_mux_six (
    .sel(chan_six_timer_sel_reg),
    .timers(timers),
    .picked(ch6_tmr),
    .picked_valid(ch6_valid)
  );

  assign ch5_cfg = '{enable: ch5_en_reg, polarity: ch5_pol_reg,
                     duty: {ch5_dch_reg, ch5_dcl_reg}};
  assign ch6_cfg = '{enable: ch6_en_reg, polarity: ch6_pol_reg,
                     duty: {ch6_dch_reg, ch6_dcl_reg}};

  pwm_channel u_chan_five (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tmr(ch5_tmr),
    .tmr_valid(ch5_valid),
    .cfg(ch5_cfg),
    .pwm_out(chan_five_out),
    .timer_clear(ch5_clear),
    .duty_latched()
  );

  pwm_channel u_chan_six (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tmr(ch6_tmr),
    .tmr_valid(ch6_valid),
    .cfg(ch6_cfg),
    .pwm_out(chan_six_out),
    .timer_clear(ch6_clear),
    .duty_latched()
  );

  // Clear request to whichever timer hit its period
  always_comb begin
    timer_clear = '0;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      timer_clear[t] = (ch5_clear && chan_five_timer_sel_reg == 2'(t + 1))
                    || (ch6_clear && chan_six_timer_sel_reg == 2'(t + 1));
    end
  end

  assign ch5_res = duty_resolution(ch5_tmr.period);
  assign ch6_res = duty_resolution(ch6_tmr.period);

  a_tsel_reset: assert property (@(posedge ref_clk)
    sys_rst |=> chan_six_timer_sel_reg == SEL_TIMER_ONE
             && chan_five_timer_sel_reg == SEL_TIMER_ONE)
    else $error("timer selects not 01 after reset");

  a_tsel_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_tsel_reg |-> hrdata[31:4] == 28'h000_0000)
    else $error("unimplemented select bits read nonzero");

  a_tsel_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_pend_reg && wr_addr_reg == OFF_TSEL
    |=> chan_six_timer_sel_reg == $past(hwdata[3:2])
     && chan_five_timer_sel_reg == $past(hwdata[1:0]))
    else $error("timer select field not written");

  a_sel_two: assert property (@(posedge ref_clk) disable iff (sys_rst)
    chan_five_timer_sel_reg == SEL_TIMER_TWO
    |-> ch5_tmr == timers[1] && ch5_valid)
    else $error("channel five not on timer two");

  a_sel_indep: assert property (@(posedge ref_clk) disable iff (sys_rst)
    chan_six_timer_sel_reg == SEL_TIMER_THREE
    |-> ch6_tmr == timers[2])
    else $error("channel six selection disturbed");

  a_res_full: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ch5_valid && ch5_tmr.period == 8'hFF |-> ch5_res == 4'hA)
    else $error("period FF not ten bit resolution");

  a_res_small: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ch6_valid && ch6_tmr.period == 8'h1F |-> ch6_res == 4'h7)
    else $error("period 1F not seven bit resolution");

  a_dcl_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    addr_phase && !hwrite && haddr[7:0] == OFF_CH5_DCL && !wr_pend_reg
    && haddr[31:8] == 24'h00_0000
    |=> hrdata == {24'h00_0000, ch5_dcl_reg, 6'h00})
    else $error("duty low read wrong");
endmodule : pwm_timer_source_select
`default_nettype wire

//--- tb/timer_model.sv
`timescale 1ns/1ps
`default_nettype none
module timer_model
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Period per timer and clear requests
  input wire logic [NUM_TIMERS-1:0][7:0] per,
  input wire logic [NUM_TIMERS-1:0] clr,
  // Timer buses
  output timer_bus_t [NUM_TIMERS-1:0] timers
);
  logic [1:0] frac_reg;
  logic [NUM_TIMERS-1:0][7:0] cnt_reg;

  // Prescale 1:1, low bits follow the clock phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      frac_reg <= 2'h0;
      cnt_reg <= '0;
    end else begin
      frac_reg <= frac_reg + 2'h1;
      for (int k = 0; k < NUM_TIMERS; k++) begin
        if (frac_reg == 2'h3) begin
          if (clr[k] || cnt_reg[k] == per[k]) begin
            cnt_reg[k] <= 8'h00;
          end else begin
            cnt_reg[k] <= cnt_reg[k] + 8'h01;
          end
        end
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_TIMERS; k++) begin
      timers[k] = '{count: cnt_reg[k], period: per[k], frac: frac_reg,
                    inc: (frac_reg == 2'h3)};
    end
  end
endmodule : timer_model
`default_nettype wire

//--- tb/pwm_timer_source_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_source_select_tb_top;
  import pwm_pkg::*;
  logic ref_clk;
  logic sys_rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  timer_bus_t [NUM_TIMERS-1:0] timers;
  logic [NUM_TIMERS-1:0] timer_clear;
  logic [NUM_TIMERS-1:0][7:0] per;
  logic chan_five_out;
  logic chan_six_out;
  int n_fail;
  int cmp_count;

  assign hready = hreadyout;

  pwm_timer_source_select u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timers(timers), .timer_clear(timer_clear),
    .chan_five_out(chan_five_out), .chan_six_out(chan_six_out));

  timer_model u_timers (.ref_clk(ref_clk), .sys_rst(sys_rst), .per(per),
    .clr(timer_clear), .timers(timers));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task chk(input string name, input logic [31:0] exp,
           input logic [31:0] got, input logic [31:0] tol);
    cmp_count++;
    if ((^got === 1'bx) || (got - exp + tol > 2 * tol)) begin
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
      n_fail++;
    end
  endtask : chk

  // One single AHB transfer; entered just after a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge ref_clk);
    while (hready !== 1'b1) begin
      @(posedge ref_clk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) begin
      @(posedge ref_clk);
    end
    // Data phase value as it stood at the accepting edge
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(name, e, x, 32'h0);
  endtask : rd_chk

  task t_regs;
    rd_chk("tsel reset", OFF_TSEL, 32'h00000005);
    rd_chk("ctrl5 reset", OFF_CH5_CTRL, 32'h00000000);
    wr(OFF_TSEL, 32'hFFFFFFFF);
    rd_chk("tsel unused bits", OFF_TSEL, 32'h0000000F);
    wr(OFF_CH5_CTRL, 32'h0000004F);
    rd_chk("ctrl5 unused bits", OFF_CH5_CTRL, 32'h00000000);
    wr(OFF_CH6_DCL, 32'h000000FF);
    rd_chk("dcl6 low bits", OFF_CH6_DCL, 32'h000000C0);
    wr(OFF_CH6_DCH, 32'h000000A5);
    rd_chk("dch6", OFF_CH6_DCH, 32'h000000A5);
    rd_chk("unmapped", 8'h40, 32'h00000000);
    wr(OFF_TSEL, 32'h00000005);
  endtask : t_regs

  // Timer one period 0x0F: one pwm period is 64 clocks
  task t_duty(input logic [7:0] ctrl, input logic [9:0] d,
              input logic [31:0] e, input logic [31:0] tol);
    logic [31:0] n;
    wr(OFF_CH5_DCH, {24'h0, d[9:2]});
    wr(OFF_CH5_DCL, {24'h0, d[1:0], 6'h00});
    wr(OFF_CH5_CTRL, {24'h0, ctrl});
    repeat (140) @(posedge ref_clk);
    n = 32'h0;
    repeat (64) begin
      @(negedge ref_clk);
      n = n + {31'h0, chan_five_out};
    end
    @(posedge ref_clk);
    chk("ch5 high clocks", e, n, tol);
  endtask : t_duty

  // Channel six on timer three (16 clocks) beside channel five
  task t_six;
    logic [31:0] n;
    wr(OFF_TSEL, 32'h0000000D);
    wr(OFF_CH6_DCH, 32'h00000002);
    wr(OFF_CH6_DCL, 32'h00000000);
    wr(OFF_CH6_CTRL, 32'h00000080);
    repeat (40) @(posedge ref_clk);
    n = 32'h0;
    repeat (16) begin
      @(negedge ref_clk);
      n = n + {31'h0, chan_six_out};
    end
    @(posedge ref_clk);
    chk("ch6 high clocks", 32'd8, n, 32'd1);
    wr(OFF_CH6_CTRL, 32'h00000010);
    repeat (2) @(posedge ref_clk);
    rd_chk("ctrl6 level", OFF_CH6_CTRL, 32'h00000030);
  endtask : t_six

  // Reset in mid-run restores both selects to timer one
  task t_reset;
    wr(OFF_TSEL, 32'h0000000E);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pins after reset", 32'h0,
        {30'h0, chan_six_out, chan_five_out}, 32'h0);
    @(posedge ref_clk);
    rd_chk("tsel after reset", OFF_TSEL, 32'h00000005);
  endtask : t_reset

  task t_select;
    logic [1:0] s5 [5];
    logic [1:0] s6 [5];
    logic [31:0] c [NUM_TIMERS];
    s5 = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h0};
    s6 = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h0};
    wr(OFF_CH5_CTRL, 32'h00000080);
    wr(OFF_CH6_CTRL, 32'h00000080);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_TSEL, {28'h0, s6[i], s5[i]});
      repeat (8) @(posedge ref_clk);
      c = '{32'h0, 32'h0, 32'h0};
      repeat (200) begin
        @(negedge ref_clk);
        for (int k = 0; k < NUM_TIMERS; k++) begin
          c[k] = c[k] + {31'h0, timer_clear[k]};
        end
      end
      @(posedge ref_clk);
      for (int k = 0; k < NUM_TIMERS; k++) begin
        chk("timer clear use", {31'h0, s5[i] == k + 1 || s6[i] == k + 1},
            {31'h0, |c[k]}, 32'h0);
      end
    end
  endtask : t_select

  task t_res;
    logic [7:0] p [3];
    logic [3:0] r [3];
    p = '{8'hFF, 8'h3F, 8'h1F};
    r = '{4'hA, 4'h8, 4'h7};
    wr(OFF_TSEL, 32'h00000005);
    for (int i = 0; i < 3; i++) begin
      per[0] <= p[i];
      repeat (4) @(posedge ref_clk);
      rd_chk("resolution", OFF_RES, {20'h0, r[i], 4'h0, r[i]});
    end
  endtask : t_res

  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    per = {8'h03, 8'h05, 8'h0F};
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_duty(8'h00, 10'd20, 32'd0, 32'd0);
    t_duty(8'h10, 10'd20, 32'd64, 32'd0);
    t_duty(8'h80, 10'd20, 32'd20, 32'd1);
    t_duty(8'h80, 10'd0, 32'd0, 32'd0);
    t_duty(8'h90, 10'd36, 32'd28, 32'd1);
    t_duty(8'h80, 10'd100, 32'd64, 32'd0);
    t_six();
    t_select();
    t_res();
    t_reset();
    end_sim();
  end

  initial begin
    #(25 * 20000);
    n_fail++;
    end_sim();
  end
endmodule : pwm_timer_source_select_tb_top
`default_nettype wire
